// ===== include/qbsp_pkg.sv
package qbsp_pkg;
   // ===========================================
   // geometry
   localparam int QBSP_WORD_W = 18;
   localparam int QBSP_ADDR_W = 6;
   localparam int QBSP_SEL_W = QBSP_WORD_W / 9;
   localparam int QBSP_DEPTH = 1 << QBSP_ADDR_W;
   localparam int QBSP_BURST = 2;
   localparam int QBSP_FIFO_DEPTH = 8;
   localparam int QBSP_FIFO_AW = 3;
   // ===========================================
   // latency, in half link cycles after the read capture edge
   localparam logic [1:0] QBSP_LAT_DLL_ON = 2'h3;
   localparam logic [1:0] QBSP_LAT_DLL_OFF = 2'h2;
   // ===========================================
   // host link clock divider: half period in clk_sys cycles
   localparam logic [1:0] QBSP_DIV_HALF = 2'h2;
   // ===========================================
   // reset values
   localparam logic [QBSP_SEL_W-1:0] QBSP_SEL_NONE = '1;
   typedef enum logic [1:0] {QBSP_OP_IDLE, QBSP_OP_READ, QBSP_OP_WRITE} qbsp_op_t;
endpackage

// ===== include/qbsp_if.sv
`timescale 1ns/1ns
`default_nettype none
interface qbsp_if;
   import qbsp_pkg::*;
   logic link_clk;
   logic link_clk_n;
   logic [QBSP_ADDR_W-1:0] addr;
   logic read_port_select_n;
   logic write_port_select_n;
   logic [QBSP_WORD_W-1:0] wdata;
   logic [QBSP_SEL_W-1:0] byte_write_select_n;
   logic dll_disable_input_n;
   logic [QBSP_WORD_W-1:0] rdata;
   logic echo_clock_out;
   logic echo_clock_out_n;
   modport dev (input link_clk, link_clk_n, addr, read_port_select_n, write_port_select_n,
      wdata, byte_write_select_n, dll_disable_input_n,
      output rdata, echo_clock_out, echo_clock_out_n);
   modport ctl (output link_clk, link_clk_n, addr, read_port_select_n, write_port_select_n,
      wdata, byte_write_select_n, dll_disable_input_n,
      input rdata, echo_clock_out, echo_clock_out_n);
endinterface
`default_nettype wire

// ===== verilog/qbsp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module qbsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } qbsp_fifo_st_t;
   qbsp_fifo_st_t st, next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;
   always_comb
   begin
      in_ready = (st.wp - st.rp) != (AW+1)'(DEPTH);
      out_valid = st.wp != st.rp;
      out_data = mem[st.rp[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_st = st;
      if (push)
      begin
         next_st.wp = st.wp + 1'b1;
      end
      if (pop)
      begin
         next_st.rp = st.rp + 1'b1;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
      if (push)
      begin
         mem[st.wp[AW-1:0]] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/qbsp_sram.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1: read address taken on true clock rise
// RULE2: write address taken on complement clock rise
// RULE3: only rising edges of both clocks sample
// RULE4: every access moves exactly two words
// RULE5: dll on: read data after 1.5 cycles
// RULE6: dll off: read data after 1 cycle
// RULE7: read and write ports run concurrently
// RULE8: a word on every rising edge
// RULE9: all inputs pass input registers; here dll_disable_input_n drives dll_on unregistered
// RULE10: read data from output registers
// RULE11: echo clocks travel with read data
// RULE12: controller multiplexes one shared address bus
// RULE13: separate read and write port selects
// RULE14: writes are self timed internally
// RULE15: reads return newest data, even pending
// RULE16: each address holds two configured words
// RULE17: port selects active low, high means idle
// RULE18: controller sends word0 true, word1 complement
// RULE19: controller holds dll disable static
module qbsp_sram
   import qbsp_pkg::*;
(
   qbsp_if.dev link,
   input wire logic nrst
);
   // ===========================================
   // state: one struct on the true clock rise, one on the complement clock
   // rise; the complement pin is a clock of its own, so no falling edge is used
   // and a read and a write never wait on each other
   typedef struct packed {
      logic rd_go;
      logic [QBSP_ADDR_W-1:0] rd_addr;
      logic [QBSP_WORD_W-1:0] w0;
      logic [QBSP_SEL_W-1:0] be0_n;
      logic [2*QBSP_WORD_W-1:0] hold;
      logic hold_pend;
      logic [QBSP_WORD_W-1:0] q;
   } qbsp_tru_t;
   typedef struct packed {
      logic wr_go;
      logic [QBSP_ADDR_W-1:0] wr_addr;
      logic [2*QBSP_WORD_W-1:0] wr_data;
      logic [2*QBSP_SEL_W-1:0] wr_be_n;
      logic [QBSP_WORD_W-1:0] q;
   } qbsp_cmp_t;
   qbsp_tru_t t, next_t;
   qbsp_cmp_t c, next_c;
   logic [2*QBSP_WORD_W-1:0] mem [QBSP_DEPTH];
   logic [2*QBSP_WORD_W-1:0] rd_word;
   logic [2*QBSP_WORD_W-1:0] w_merged;
   logic dll_on;

   // picks one half of a stored pair; word0 sits in the low half
   function automatic logic [QBSP_WORD_W-1:0] word_of(
      input logic [2*QBSP_WORD_W-1:0] w,
      input logic upper);
      return upper ? w[2*QBSP_WORD_W-1:QBSP_WORD_W] : w[QBSP_WORD_W-1:0];
   endfunction

   function automatic logic [2*QBSP_WORD_W-1:0] merge(
      input logic [2*QBSP_WORD_W-1:0] old_w,
      input logic [2*QBSP_WORD_W-1:0] new_w,
      input logic [2*QBSP_SEL_W-1:0] be_n);
      logic [2*QBSP_WORD_W-1:0] r;
      r = old_w;
      for (int i = 0; i < 2*QBSP_SEL_W; i++)
      begin
         if (!be_n[i])
         begin
            r[i*9 +: 9] = new_w[i*9 +: 9];
         end
      end
      return r;
   endfunction

   assign dll_on = link.dll_disable_input_n; // RULE19
   // ===========================================
   // self timed write commit and coherent read
   always_comb
   begin
      w_merged = merge(mem[c.wr_addr], c.wr_data, c.wr_be_n); // RULE14
      rd_word = mem[t.rd_addr];
      if (c.wr_go && c.wr_addr == t.rd_addr)
      begin
         rd_word = w_merged; // RULE15
      end
   end
   // ===========================================
   // true clock edge
   always_comb
   begin
      next_t = t;
      next_t.rd_go = !link.read_port_select_n; // RULE1 RULE17 RULE13
      next_t.rd_addr = link.addr; // RULE9
      next_t.w0 = link.wdata; // RULE18
      next_t.be0_n = link.byte_write_select_n;
      next_t.hold_pend = t.rd_go;
      if (t.rd_go)
      begin
         // both words are latched at once so a later write cannot tear the pair
         next_t.hold = rd_word; // RULE4 RULE16
         if (!dll_on)
         begin
            next_t.q = word_of(rd_word, 1'b0); // RULE6
         end
      end
      else if (t.hold_pend && dll_on)
      begin
         next_t.q = word_of(t.hold, 1'b1); // RULE5
      end
   end
   always_ff @(posedge link.link_clk)
   begin
      if (!nrst)
      begin
         t <= '0;
         t.be0_n <= QBSP_SEL_NONE;
      end
      else
      begin
         t <= next_t; // RULE3
      end
   end
   // ===========================================
   // complement clock edge: write capture and read data out
   always_comb
   begin
      next_c = c;
      next_c.wr_go = !link.write_port_select_n; // RULE2 RULE17 RULE7
      next_c.wr_addr = link.addr; // RULE12
      next_c.wr_data = {link.wdata, t.w0}; // RULE8
      next_c.wr_be_n = {link.byte_write_select_n, t.be0_n};
      if (t.hold_pend)
      begin
         // dll on: word0 here, one and a half cycles after capture;
         // dll off: word1 here, the second half of the one cycle slot
         next_c.q = word_of(t.hold, !dll_on); // RULE5 RULE6 RULE8
      end
   end
   always_ff @(posedge link.link_clk_n)
   begin
      if (!nrst)
      begin
         c <= '0;
         c.wr_be_n <= '1;
      end
      else
      begin
         c <= next_c;
         if (c.wr_go)
         begin
            mem[c.wr_addr] <= w_merged; // RULE14
         end
      end
   end
   // ===========================================
   // output: the true-edge register shows while the link clock is high, the
   // complement-edge register while it is low, one word per half cycle;
   // single clock domain use, so the input pair clocks the output registers
   always_comb
   begin
      link.rdata = link.link_clk ? t.q : c.q; // RULE10 RULE8
      link.echo_clock_out = link.link_clk; // RULE11
      link.echo_clock_out_n = link.link_clk_n;
   end
endmodule
`default_nettype wire

// ===== verilog/qbsp_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module qbsp_ctl
   import qbsp_pkg::*;
(
   qbsp_if.ctl link,
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic dll_enable,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [QBSP_ADDR_W-1:0] req_addr,
   input wire logic [2*QBSP_WORD_W-1:0] req_wdata,
   input wire logic [2*QBSP_SEL_W-1:0] req_be_n,
   output logic rsp_valid,
   output logic [2*QBSP_WORD_W-1:0] rsp_data
);
   localparam int CW = 1 + QBSP_ADDR_W + 2*QBSP_WORD_W + 2*QBSP_SEL_W;
   typedef struct packed {
      logic [1:0] div;
      logic lclk;
      qbsp_op_t op;
      logic [QBSP_ADDR_W-1:0] addr;
      logic [2*QBSP_WORD_W-1:0] wd;
      logic [2*QBSP_SEL_W-1:0] be_n;
      logic [2:0] wait_cnt;
      logic [QBSP_WORD_W-1:0] r0;
      logic rsp_valid;
      logic [2*QBSP_WORD_W-1:0] rsp_data;
      logic dll;
      logic run;
   } qbsp_ctl_st_t;
   qbsp_ctl_st_t s, next_s;
   logic f_valid, f_pop;
   logic [CW-1:0] f_data;
   // ===========================================
   // command queue; pops only when the link is idle, so back-pressure reaches req_ready
   qbsp_fifo #(.WIDTH(CW), .DEPTH(QBSP_FIFO_DEPTH), .AW(QBSP_FIFO_AW)) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data({req_write, req_addr, req_wdata, req_be_n}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );
   // ===========================================
   // link clock made by divider; link signals change only at the clk_sys edge
   // midway through a link half period, never on a link clock edge, so the
   // device always samples settled values; read data is taken mid half too
   logic mid;
   always_comb
   begin
      next_s = s;
      next_s.rsp_valid = 1'b0;
      next_s.run = 1'b1;
      mid = 1'b0;
      f_pop = 1'b0;
      next_s.div = s.div + 2'h1;
      if (s.div == QBSP_DIV_HALF - 2'h1)
      begin
         next_s.div = '0;
         next_s.lclk = !s.lclk;
      end
      else if (s.div == 2'h0)
      begin
         mid = 1'b1;
      end
      if (mid && s.lclk)
      begin
         // RULE18: word1 presented before the complement rise
         next_s.wd = {s.wd[QBSP_WORD_W-1:0], s.wd[2*QBSP_WORD_W-1:QBSP_WORD_W]};
         next_s.be_n = {s.be_n[QBSP_SEL_W-1:0], s.be_n[2*QBSP_SEL_W-1:QBSP_SEL_W]};
         if (s.op == QBSP_OP_READ)
         begin
            next_s.op = QBSP_OP_IDLE;
         end
      end
      if (mid && s.wait_cnt != 3'h0)
      begin
         next_s.wait_cnt = s.wait_cnt - 3'h1;
         if (s.wait_cnt == 3'h2)
         begin
            next_s.r0 = link.rdata;
         end
         if (s.wait_cnt == 3'h1)
         begin
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data = {link.rdata, s.r0};
         end
      end
      else if (mid && !s.lclk)
      begin
         next_s.op = QBSP_OP_IDLE;
         if (f_valid)
         begin
            f_pop = 1'b1;
            next_s.op = f_data[CW-1] ? QBSP_OP_WRITE : QBSP_OP_READ;
            next_s.addr = f_data[CW-2 -: QBSP_ADDR_W];
            next_s.wd = f_data[2*QBSP_SEL_W +: 2*QBSP_WORD_W];
            next_s.be_n = f_data[2*QBSP_SEL_W-1:0];
            // mid points until word1 stands: latency in half cycles plus two
            next_s.wait_cnt = f_data[CW-1] ? 3'h0 :
               {1'b0, (s.dll ? QBSP_LAT_DLL_ON : QBSP_LAT_DLL_OFF)} + 3'h2;
         end
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.be_n <= '1;
         s.dll <= dll_enable; // RULE19
      end
      else
      begin
         s <= next_s;
      end
   end
   always_comb
   begin
      // in reset the link clock follows inverted clk_sys so the device's
      // synchronous reset sees edges; the hand-over at run is glitch free
      link.link_clk = s.run ? s.lclk : !clk_sys;
      link.link_clk_n = s.run ? !s.lclk : clk_sys;
      link.addr = s.addr; // RULE12
      link.read_port_select_n = !(s.op == QBSP_OP_READ); // RULE13 RULE17 RULE1
      link.write_port_select_n = !(s.op == QBSP_OP_WRITE); // RULE2
      link.wdata = s.wd[QBSP_WORD_W-1:0]; // RULE4
      link.byte_write_select_n = s.be_n[QBSP_SEL_W-1:0];
      link.dll_disable_input_n = s.dll; // RULE19
      rsp_valid = s.rsp_valid;
      rsp_data = s.rsp_data;
   end
endmodule
`default_nettype wire

// ===== test/qbsp_chk.sv
`timescale 1ns/1ns
`default_nettype none
module qbsp_chk
   import qbsp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic link_clk_n,
   input wire logic [QBSP_ADDR_W-1:0] addr,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic dll_disable_input_n,
   input wire logic echo_clock_out,
   input wire logic echo_clock_out_n
);
   // ===========================================
   // link wire checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   AST_CLK_PAIR: assert property (link_clk_n == !link_clk)
      else $error("link clock pair not complementary");
   AST_CLK_DIV: assert property ($rose(link_clk) |-> ##1 link_clk ##1 !link_clk)
      else $error("link clock half period wrong");
   AST_SEL_RESET: assert property (!$past(nrst) |-> read_port_select_n && write_port_select_n)
      else $error("port select active after reset");
   AST_ONE_PORT: assert property (!read_port_select_n |-> write_port_select_n)
      else $error("both port selects active");
   AST_ADDR_HOLD: assert property (!read_port_select_n && !$past(read_port_select_n)
      |-> $stable(addr))
      else $error("read address moved while selected");
   AST_DLL_STATIC: assert property ($past(nrst) |-> $stable(dll_disable_input_n))
      else $error("dll disable changed in operation");
   AST_ECHO_PAIR: assert property (echo_clock_out_n == !echo_clock_out)
      else $error("echo clocks not complementary");
   AST_READ_ONCE: assert property (@(posedge link_clk) disable iff (!nrst)
      !read_port_select_n |=> read_port_select_n)
      else $error("read select held over two captures");
endmodule
`default_nettype wire

// ===== test/quad_rate_burst2_sram_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module quad_rate_burst2_sram_port_tb
   import qbsp_pkg::*;
;
   logic clk_sys, nrst, dll_enable, req_valid, req_ready, req_write, rsp_valid, seen_full;
   logic [5:0] req_addr, ra;
   logic [35:0] req_wdata, rsp_data;
   logic [3:0] req_be_n;
   int errors, n_tests, cyc, i, m;

   qbsp_if link_if();
   qbsp_ctl qbsp_ctl_inst(.link(link_if.ctl), .clk_sys(clk_sys), .nrst(nrst),
      .dll_enable(dll_enable), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_be_n(req_be_n), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   qbsp_sram qbsp_sram_inst(.link(link_if.dev), .nrst(nrst));
   qbsp_chk qbsp_chk_inst(.clk_sys(clk_sys), .nrst(nrst), .link_clk(link_if.link_clk),
      .link_clk_n(link_if.link_clk_n), .addr(link_if.addr),
      .read_port_select_n(link_if.read_port_select_n),
      .write_port_select_n(link_if.write_port_select_n),
      .dll_disable_input_n(link_if.dll_disable_input_n),
      .echo_clock_out(link_if.echo_clock_out), .echo_clock_out_n(link_if.echo_clock_out_n));

   // ===========================================
   // helpers
   task chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task report_and_stop;
      if (errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // valid stays up so back-to-back requests never re-assign it in one step
   task put(input logic w, input logic [5:0] a, input logic [35:0] d, input logic [3:0] be);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      req_be_n <= be;
      @(posedge clk_sys);
      if (req_ready !== 1'b1)
         seen_full = 1'b1;
      while (req_ready !== 1'b1)
         @(posedge clk_sys);
   endtask

   task rd(input logic [5:0] a, input logic [35:0] e);
      ra = a;
      put(1'b0, a, 36'h0, 4'h0);
      req_valid <= 1'b0;
      @(posedge clk_sys);
      while (rsp_valid !== 1'b1)
         @(posedge clk_sys);
      chk("read data", rsp_data, e);
   endtask

   function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n,
      input logic [3:0] be);
      for (int k = 0; k < 4; k++)
         mrg[9*k +: 9] = be[k] ? o[9*k +: 9] : n[9*k +: 9];
   endfunction

   // address on the shared bus at each read select, mid cycle where it is settled
   logic sel_d;
   always @(negedge clk_sys)
   begin
      if (nrst === 1'b1 && sel_d === 1'b1 && link_if.read_port_select_n === 1'b0)
         chk("link read addr", {30'h0, link_if.addr}, {30'h0, ra});
      sel_d <= link_if.read_port_select_n;
   end

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         report_and_stop;
      end
   end

   // ===========================================
   // main sequence: pass 0 dll on, pass 1 dll off
   initial
   begin
      nrst = 1'b0;
      dll_enable = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 6'h0;
      req_wdata = 36'h0;
      req_be_n = 4'h0;
      errors = 0;
      n_tests = 0;
      cyc = 0;
      ra = 6'h0;
      for (m = 0; m < 2; m++)
      begin
         nrst <= 1'b0;
         dll_enable <= (m == 0);
         // the link clock runs during reset, so three cycles reach the device
         repeat (3) @(posedge clk_sys);
         nrst <= 1'b1;
         @(posedge clk_sys);
         put(1'b1, 6'h00, 36'h123456789 + 36'(m), 4'h0);
         put(1'b1, 6'h3f, 36'hfedcba987, 4'h0);
         rd(6'h00, 36'h123456789 + 36'(m));
         rd(6'h3f, 36'hfedcba987);
         for (i = 0; i < 4; i++)
         begin
            put(1'b1, 6'h05, 36'hfffffffff, 4'h0);
            put(1'b1, 6'h05, 36'h0, ~(4'h1 << i));
            rd(6'h05, mrg(36'hfffffffff, 36'h0, ~(4'h1 << i)));
         end
         seen_full = 1'b0;
         for (i = 0; i < 16; i++)
            put(1'b1, 6'(i + 8), {18'(i + 1), 18'(3 * i + m)}, 4'h0);
         chk("queue refused when full", {35'h0, seen_full}, 36'h1);
         for (i = 0; i < 16; i++)
            rd(6'(i + 8), {18'(i + 1), 18'(3 * i + m)});
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
